// ===== rtl/iex_pkg.sv
// iex_pkg: opcodes, field layouts and constants of the instruction execute subset
// assumes: used by iex_exec and iex_filemem, referenced with package scope only
package iex_pkg;
  localparam int IEX_AW = 7;
  localparam int IEX_DW = 8;
  localparam int IEX_FILE_WORDS = 128;
  localparam logic [6:0] IEX_DIR_A = 7'h05;
  localparam logic [6:0] IEX_DIR_B = 7'h06;
  localparam logic [6:0] IEX_DIR_C = 7'h07;
  localparam logic [7:0] IEX_W_RST = 8'h00;
  localparam logic [7:0] IEX_DIR_RST = 8'hFF;
  localparam logic [7:0] IEX_WDOG_CLR = 8'h00;
  localparam logic [7:0] IEX_PRESC_CLR = 8'h00;
  localparam int IEX_LO_MSB = 3;
  localparam int IEX_HI_LSB = 4;
  typedef enum logic [3:0] {
    IEX_OP_NOP = 4'h0,
    IEX_OP_ROTATE_RIGHT_VIA_CARRY = 4'h1,
    IEX_OP_LITERAL_MINUS_ACCUMULATOR = 4'h2,
    IEX_OP_FILE_MINUS_ACCUMULATOR = 4'h3,
    IEX_OP_FILE_MINUS_ACCUMULATOR_BORROW = 4'h4,
    IEX_OP_NIBBLE_EXCHANGE = 4'h5,
    IEX_OP_EXCLUSIVE_OR_LITERAL = 4'h6,
    IEX_OP_EXCLUSIVE_OR_FILE = 4'h7,
    IEX_OP_LOAD_DIRECTION_REGISTER = 4'h8,
    IEX_OP_SLEEP = 4'h9
  } iex_op_t;
  typedef enum logic [1:0] {
    IEX_ST_IDLE = 2'b00,
    IEX_ST_EXEC = 2'b01,
    IEX_ST_HALT = 2'b10
  } iex_state_t;
endpackage : iex_pkg

// ===== rtl/iex_filemem.sv
// iex_filemem: 128 x 8 file register memory, registered read data
// assumes: one clock, read address presented one cycle before data is used
`timescale 1ns/100ps
`default_nettype none
module iex_filemem (
  // clock
  input wire logic clk,
  // read port
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data,
  // write port
  input wire logic wr_en,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data
);
  // power-up contents zero: every file result derives from a file read,
  // so an unknown ram could never reach a known value
  logic [7:0] mem [iex_pkg::IEX_FILE_WORDS] = '{default: 8'h00};
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : iex_filemem
`default_nettype wire

// ===== rtl/iex_exec.sv
// iex_exec: executes a subset of an 8-bit core instruction set
// assumes: one instruction presented with start while ready is high; wake ends sleep
`timescale 1ns/100ps
`default_nettype none
module iex_exec (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // instruction
  input wire logic start,
  input wire logic [3:0] opcode,
  input wire logic [6:0] file_addr,
  input wire logic dest_bit,
  input wire logic [7:0] literal,
  // wake from sleep
  input wire logic wake,
  // status
  output logic ready,
  output logic done,
  output logic [7:0] accumulator,
  output logic carry_flag,
  output logic half_byte_borrow_flag,
  output logic zero_flag,
  output logic expiry_flag,
  output logic power_down_flag,
  output logic [7:0] watchdog_counter,
  output logic [7:0] watchdog_prescaler,
  output logic osc_run,
  output logic [7:0] dir_a,
  output logic [7:0] dir_b,
  output logic [7:0] dir_c
);
  typedef struct packed {
    iex_pkg::iex_state_t st;
    iex_pkg::iex_op_t op;
    logic [6:0] addr;
    logic dst;
    logic [7:0] lit;
    logic done;
    logic rdy;
    logic wk1;
    logic wk2;
    logic [7:0] w;
    logic c;
    logic hb;
    logic z;
    logic exp_f;
    logic pdn_f;
    logic [7:0] wdog;
    logic [7:0] pre;
    logic osc;
    logic [7:0] ta;
    logic [7:0] tb;
    logic [7:0] tc;
  } iex_state_s_t;

  iex_state_s_t s_q, s_d;
  logic [7:0] f_rd;
  logic f_we;
  logic [7:0] f_wd;

  iex_filemem u_mem (
    .clk(clk),
    .rd_addr(file_addr),
    .rd_data(f_rd),
    .wr_en(f_we),
    .wr_addr(s_q.addr),
    .wr_data(f_wd)
  );

  logic [8:0] diff;
  logic [4:0] ldiff;
  logic [7:0] res;
  logic [7:0] a_op;
  logic b_in;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    // wake comes from outside the stopped clock: two flops before use
    s_d.wk1 = wake;
    s_d.wk2 = s_q.wk1;
    f_we = 1'b0;
    f_wd = 8'h00;
    res = 8'h00;
    b_in = ~s_q.c;
    a_op = (s_q.op == iex_pkg::IEX_OP_LITERAL_MINUS_ACCUMULATOR) ? s_q.lit : f_rd;
    if (s_q.op != iex_pkg::IEX_OP_FILE_MINUS_ACCUMULATOR_BORROW) begin
      b_in = 1'b0;
    end
    // 9-bit subtract: bit 8 set means borrow, so carry is its inverse
    diff = {1'b0, a_op} - {1'b0, s_q.w} - {8'h00, b_in};
    ldiff = {1'b0, a_op[3:0]} - {1'b0, s_q.w[3:0]} - {4'h0, b_in};
    case (s_q.st)
      iex_pkg::IEX_ST_IDLE: begin
        if (start) begin
          s_d.op = iex_pkg::iex_op_t'(opcode);
          s_d.addr = file_addr;
          s_d.dst = dest_bit;
          s_d.lit = literal;
          s_d.st = iex_pkg::IEX_ST_EXEC;
        end
      end
      iex_pkg::IEX_ST_EXEC: begin
        s_d.st = iex_pkg::IEX_ST_IDLE;
        s_d.done = 1'b1;
        case (s_q.op)
          iex_pkg::IEX_OP_ROTATE_RIGHT_VIA_CARRY: begin
            res = {s_q.c, f_rd[7:1]};
            s_d.c = f_rd[0];
          end
          iex_pkg::IEX_OP_LITERAL_MINUS_ACCUMULATOR,
          iex_pkg::IEX_OP_FILE_MINUS_ACCUMULATOR,
          iex_pkg::IEX_OP_FILE_MINUS_ACCUMULATOR_BORROW: begin
            res = diff[7:0];
            s_d.c = ~diff[8];
            s_d.hb = ~ldiff[4];
            s_d.z = (diff[7:0] == 8'h00);
          end
          iex_pkg::IEX_OP_NIBBLE_EXCHANGE: begin
            res = {f_rd[iex_pkg::IEX_LO_MSB:0], f_rd[7:iex_pkg::IEX_HI_LSB]};
          end
          iex_pkg::IEX_OP_EXCLUSIVE_OR_LITERAL,
          iex_pkg::IEX_OP_EXCLUSIVE_OR_FILE: begin
            res = s_q.w ^ ((s_q.op == iex_pkg::IEX_OP_EXCLUSIVE_OR_LITERAL) ? s_q.lit : f_rd);
            s_d.z = (res == 8'h00);
          end
          iex_pkg::IEX_OP_LOAD_DIRECTION_REGISTER: begin
            if (s_q.addr == iex_pkg::IEX_DIR_A) begin
              s_d.ta = s_q.w;
            end else if (s_q.addr == iex_pkg::IEX_DIR_B) begin
              s_d.tb = s_q.w;
            end else if (s_q.addr == iex_pkg::IEX_DIR_C) begin
              s_d.tc = s_q.w;
            end
          end
          iex_pkg::IEX_OP_SLEEP: begin
            s_d.pdn_f = 1'b0;
            s_d.exp_f = 1'b1;
            s_d.wdog = iex_pkg::IEX_WDOG_CLR;
            s_d.pre = iex_pkg::IEX_PRESC_CLR;
            s_d.osc = 1'b0;
            s_d.st = iex_pkg::IEX_ST_HALT;
          end
          default: begin
          end
        endcase
        // literal forms always target the accumulator
        case (s_q.op)
          iex_pkg::IEX_OP_LITERAL_MINUS_ACCUMULATOR,
          iex_pkg::IEX_OP_EXCLUSIVE_OR_LITERAL: begin
            s_d.w = res;
          end
          iex_pkg::IEX_OP_ROTATE_RIGHT_VIA_CARRY,
          iex_pkg::IEX_OP_FILE_MINUS_ACCUMULATOR,
          iex_pkg::IEX_OP_FILE_MINUS_ACCUMULATOR_BORROW,
          iex_pkg::IEX_OP_NIBBLE_EXCHANGE,
          iex_pkg::IEX_OP_EXCLUSIVE_OR_FILE: begin
            if (s_q.dst) begin
              f_we = 1'b1;
              f_wd = res;
            end else begin
              s_d.w = res;
            end
          end
          default: begin
          end
        endcase
      end
      iex_pkg::IEX_ST_HALT: begin
        // oscillator off: only wake restarts the core
        if (s_q.wk2) begin
          s_d.osc = 1'b1;
          s_d.st = iex_pkg::IEX_ST_IDLE;
        end
      end
      default: begin
        s_d.st = iex_pkg::IEX_ST_IDLE;
      end
    endcase
    s_d.rdy = (s_d.st == iex_pkg::IEX_ST_IDLE);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{st: iex_pkg::IEX_ST_IDLE, op: iex_pkg::IEX_OP_NOP, addr: 7'h00, dst: 1'b0,
               lit: 8'h00, done: 1'b0, rdy: 1'b1, wk1: 1'b0, wk2: 1'b0,
               w: iex_pkg::IEX_W_RST, c: 1'b0, hb: 1'b0, z: 1'b0,
               exp_f: 1'b1, pdn_f: 1'b1, wdog: 8'h00, pre: 8'h00, osc: 1'b1,
               ta: iex_pkg::IEX_DIR_RST, tb: iex_pkg::IEX_DIR_RST, tc: iex_pkg::IEX_DIR_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign ready = s_q.rdy;
  assign done = s_q.done;
  assign accumulator = s_q.w;
  assign carry_flag = s_q.c;
  assign half_byte_borrow_flag = s_q.hb;
  assign zero_flag = s_q.z;
  assign expiry_flag = s_q.exp_f;
  assign power_down_flag = s_q.pdn_f;
  assign watchdog_counter = s_q.wdog;
  assign watchdog_prescaler = s_q.pre;
  assign osc_run = s_q.osc;
  assign dir_a = s_q.ta;
  assign dir_b = s_q.tb;
  assign dir_c = s_q.tc;

  // assertions
  rot_carry_a: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.st == iex_pkg::IEX_ST_EXEC && s_q.op == iex_pkg::IEX_OP_ROTATE_RIGHT_VIA_CARRY)
    |=> carry_flag == $past(f_rd[0])) else $error("rotate carry wrong");
  dest_w_a: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.st == iex_pkg::IEX_ST_EXEC && s_q.op == iex_pkg::IEX_OP_NIBBLE_EXCHANGE && s_q.dst)
    |=> accumulator == $past(accumulator)) else $error("dest 1 changed accumulator");
  lit_sub_a: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.st == iex_pkg::IEX_ST_EXEC && s_q.op == iex_pkg::IEX_OP_LITERAL_MINUS_ACCUMULATOR)
    |=> accumulator == 8'($past(s_q.lit) - $past(accumulator))
        && carry_flag == ($past(accumulator) <= $past(s_q.lit))) else $error("literal subtract");
  file_sub_a: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.st == iex_pkg::IEX_ST_EXEC && s_q.op == iex_pkg::IEX_OP_FILE_MINUS_ACCUMULATOR)
    |=> carry_flag == ($past(accumulator) <= $past(f_rd))
        && half_byte_borrow_flag == ($past(accumulator[3:0]) <= $past(f_rd[3:0])))
    else $error("file subtract flags");
  borrow_sub_a: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.st == iex_pkg::IEX_ST_EXEC && s_q.op == iex_pkg::IEX_OP_FILE_MINUS_ACCUMULATOR_BORROW
     && !s_q.dst)
    |=> accumulator == 8'($past(f_rd) - $past(accumulator) - {7'h00, ~$past(carry_flag)}))
    else $error("borrow subtract");
  swap_flags_a: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.st == iex_pkg::IEX_ST_EXEC && s_q.op == iex_pkg::IEX_OP_NIBBLE_EXCHANGE)
    |=> $stable({carry_flag, half_byte_borrow_flag, zero_flag})) else $error("swap flags");
  xor_lit_a: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.st == iex_pkg::IEX_ST_EXEC && s_q.op == iex_pkg::IEX_OP_EXCLUSIVE_OR_LITERAL)
    |=> accumulator == ($past(accumulator) ^ $past(s_q.lit)) && $stable(carry_flag))
    else $error("xor literal");
  dir_load_a: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.st == iex_pkg::IEX_ST_EXEC && s_q.op == iex_pkg::IEX_OP_LOAD_DIRECTION_REGISTER
     && s_q.addr == iex_pkg::IEX_DIR_B) |=> dir_b == $past(accumulator) && $stable(dir_a))
    else $error("direction load");
  sleep_flags_a: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.st == iex_pkg::IEX_ST_EXEC && s_q.op == iex_pkg::IEX_OP_SLEEP)
    |=> !power_down_flag && expiry_flag) else $error("sleep flags");
  sleep_halt_a: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.st == iex_pkg::IEX_ST_EXEC && s_q.op == iex_pkg::IEX_OP_SLEEP)
    |=> watchdog_counter == 8'h00 && watchdog_prescaler == 8'h00 && !osc_run && !ready)
    else $error("sleep halt");
  zero_res_a: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.st == iex_pkg::IEX_ST_EXEC && s_q.op == iex_pkg::IEX_OP_EXCLUSIVE_OR_FILE && !s_q.dst)
    |=> zero_flag == (accumulator == 8'h00)) else $error("zero flag");
  xor_file_a: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.st == iex_pkg::IEX_ST_EXEC && s_q.op == iex_pkg::IEX_OP_EXCLUSIVE_OR_FILE && !s_q.dst)
    |=> accumulator == ($past(accumulator) ^ $past(f_rd)) && $stable(carry_flag))
    else $error("xor file");
  cov_sub_c: cover property (@(posedge clk) disable iff (!resetn)
    s_q.st == iex_pkg::IEX_ST_EXEC && s_q.op == iex_pkg::IEX_OP_FILE_MINUS_ACCUMULATOR_BORROW);
  cov_sleep_c: cover property (@(posedge clk) disable iff (!resetn)
    s_q.st == iex_pkg::IEX_ST_HALT ##1 s_q.st == iex_pkg::IEX_ST_IDLE);
  cov_wr_c: cover property (@(posedge clk) disable iff (!resetn) f_we);
endmodule : iex_exec
`default_nettype wire

// ===== testbench/mcu_instruction_execute_subset_bench.sv
// mcu_instruction_execute_subset_bench: directed scenarios for iex_exec
// assumes: inputs driven at falling edge, file memory powers up cleared
`timescale 1ns/100ps
`default_nettype none
module mcu_instruction_execute_subset_bench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic [3:0] opcode = 4'h0;
  logic [6:0] file_addr = 7'h00;
  logic dest_bit = 1'b0;
  logic [7:0] literal = 8'h00;
  logic wake = 1'b0;
  logic ready, done, carry_flag, half_byte_borrow_flag, zero_flag;
  logic expiry_flag, power_down_flag, osc_run;
  logic [7:0] accumulator, watchdog_counter, watchdog_prescaler, dir_a, dir_b, dir_c;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [7:0] w_exp;

  always #2 clk = ~clk;

  iex_exec DUT (
    .clk(clk), .resetn(resetn), .start(start), .opcode(opcode), .file_addr(file_addr),
    .dest_bit(dest_bit), .literal(literal), .wake(wake), .ready(ready), .done(done),
    .accumulator(accumulator), .carry_flag(carry_flag),
    .half_byte_borrow_flag(half_byte_borrow_flag), .zero_flag(zero_flag),
    .expiry_flag(expiry_flag), .power_down_flag(power_down_flag),
    .watchdog_counter(watchdog_counter), .watchdog_prescaler(watchdog_prescaler),
    .osc_run(osc_run), .dir_a(dir_a), .dir_b(dir_b), .dir_c(dir_c)
  );

  task automatic tally_and_finish();
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // generous ceiling: the whole run needs under a hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      tally_and_finish();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // one instruction: request held until the take edge, then wait for done
  task automatic exec(input logic [3:0] op, input logic [6:0] fa, input logic d,
                      input logic [7:0] k);
    int n;
    n = 0;
    start = 1'b1;
    opcode = op;
    file_addr = fa;
    dest_bit = d;
    literal = k;
    @(negedge clk);
    start = 1'b0;
    while (done !== 1'b1 && n < 6) begin
      @(negedge clk);
      n = n + 1;
    end
    check({7'h00, done}, 8'h01, "done");
    check(n == 1 ? 8'h01 : 8'h00, 8'h01, "latency");
  endtask : exec

  task automatic set_w(input logic [7:0] v);
    exec(iex_pkg::IEX_OP_EXCLUSIVE_OR_LITERAL, 7'h00, 1'b0, w_exp ^ v);
    w_exp = v;
  endtask : set_w

  task automatic t_xor_literal();
    exec(iex_pkg::IEX_OP_EXCLUSIVE_OR_LITERAL, 7'h00, 1'b0, 8'h3C);
    check(accumulator, 8'h3C, "xor acc");
    check({7'h00, zero_flag}, 8'h00, "xor zero clear");
    exec(iex_pkg::IEX_OP_EXCLUSIVE_OR_LITERAL, 7'h00, 1'b0, 8'h3C);
    check(accumulator, 8'h00, "xor acc zero");
    check({6'h00, carry_flag, zero_flag}, 8'h01, "xor flags");
    w_exp = 8'h00;
  endtask : t_xor_literal

  task automatic t_literal_minus();
    logic [7:0] wv [4] = '{8'h10, 8'h21, 8'h0F, 8'hFF};
    logic [7:0] kv [4] = '{8'h10, 8'h12, 8'h20, 8'h00};
    logic [7:0] r;
    for (int i = 0; i < 4; i++) begin
      set_w(wv[i]);
      r = kv[i] - wv[i];
      exec(iex_pkg::IEX_OP_LITERAL_MINUS_ACCUMULATOR, 7'h00, 1'b0, kv[i]);
      check(accumulator, r, "lit minus acc");
      check({7'h00, carry_flag}, {7'h00, wv[i] <= kv[i]}, "lit minus carry");
      check({7'h00, half_byte_borrow_flag}, {7'h00, wv[i][3:0] <= kv[i][3:0]},
            "lit minus half");
      check({7'h00, zero_flag}, {7'h00, r == 8'h00}, "lit minus zero");
      w_exp = r;
    end
  endtask : t_literal_minus

  task automatic t_refused();
    set_w(8'h00);
    start = 1'b1;
    opcode = iex_pkg::IEX_OP_EXCLUSIVE_OR_LITERAL;
    literal = 8'h5A;
    @(negedge clk);
    literal = 8'hA5;
    @(negedge clk);
    start = 1'b0;
    check({7'h00, done}, 8'h01, "done after one take");
    check(accumulator, 8'h5A, "second start ignored while busy");
    @(negedge clk);
    w_exp = 8'h5A;
  endtask : t_refused

  task automatic t_direction();
    logic [2:0] fl;
    fl = {carry_flag, half_byte_borrow_flag, zero_flag};
    for (int i = 5; i <= 7; i++) begin
      set_w(8'h10 + 8'(i));
      exec(iex_pkg::IEX_OP_LOAD_DIRECTION_REGISTER, 7'(i), 1'b0, 8'h00);
    end
    set_w(8'h99);
    exec(iex_pkg::IEX_OP_LOAD_DIRECTION_REGISTER, 7'h04, 1'b0, 8'h00);
    check(dir_a, 8'h15, "dir a");
    check(dir_b, 8'h16, "dir b");
    check(dir_c, 8'h17, "dir c");
    check({5'h00, carry_flag, half_byte_borrow_flag, zero_flag}, {5'h00, fl},
          "dir flags");
  endtask : t_direction

  // file side judged through flags and an untouched accumulator
  task automatic t_file_to_file();
    logic [1:0] cd;
    cd = {carry_flag, half_byte_borrow_flag};
    exec(iex_pkg::IEX_OP_NIBBLE_EXCHANGE, 7'h7F, 1'b1, 8'h00);
    check(accumulator, w_exp, "swap keeps acc");
    check({6'h00, cd}, {6'h00, carry_flag, half_byte_borrow_flag}, "swap flags");
    exec(iex_pkg::IEX_OP_EXCLUSIVE_OR_FILE, 7'h7F, 1'b1, 8'h00);
    check(accumulator, w_exp, "xor file keeps acc");
    check({6'h00, cd}, {6'h00, carry_flag, half_byte_borrow_flag}, "xor file flags");
  endtask : t_file_to_file

  // file results read back by exclusive-or into the accumulator, cleared for the first read
  task automatic t_file_ops();
    set_w(8'hA5);
    exec(iex_pkg::IEX_OP_EXCLUSIVE_OR_FILE, 7'h20, 1'b1, 8'h00);
    set_w(8'h00);
    exec(iex_pkg::IEX_OP_EXCLUSIVE_OR_FILE, 7'h20, 1'b0, 8'h00);
    check(accumulator, 8'hA5, "xor file into acc");
    check({7'h00, zero_flag}, 8'h00, "xor file zero");
    w_exp = 8'hA5;
    set_w(8'h01);
    exec(iex_pkg::IEX_OP_LITERAL_MINUS_ACCUMULATOR, 7'h00, 1'b0, 8'h01);
    exec(iex_pkg::IEX_OP_ROTATE_RIGHT_VIA_CARRY, 7'h20, 1'b0, 8'h00);
    check(accumulator, 8'hD2, "rotate to acc");
    check({7'h00, carry_flag}, 8'h01, "rotate carry");
    exec(iex_pkg::IEX_OP_ROTATE_RIGHT_VIA_CARRY, 7'h20, 1'b1, 8'h00);
    exec(iex_pkg::IEX_OP_EXCLUSIVE_OR_FILE, 7'h20, 1'b0, 8'h00);
    check(accumulator, 8'h00, "rotate to file");
    check({7'h00, zero_flag}, 8'h01, "xor file zero set");
    w_exp = 8'h00;
    set_w(8'h13);
    exec(iex_pkg::IEX_OP_FILE_MINUS_ACCUMULATOR, 7'h20, 1'b0, 8'h00);
    check(accumulator, 8'hBF, "file minus acc");
    check({6'h00, carry_flag, half_byte_borrow_flag}, 8'h02, "file minus flags");
    w_exp = 8'hBF;
    set_w(8'hE0);
    exec(iex_pkg::IEX_OP_FILE_MINUS_ACCUMULATOR, 7'h20, 1'b0, 8'h00);
    check(accumulator, 8'hF2, "file minus wraps");
    check({6'h00, carry_flag, half_byte_borrow_flag}, 8'h01, "file minus borrow");
    w_exp = 8'hF2;
    set_w(8'h02);
    exec(iex_pkg::IEX_OP_FILE_MINUS_ACCUMULATOR_BORROW, 7'h20, 1'b0, 8'h00);
    check(accumulator, 8'hCF, "borrow minus acc");
    check({5'h00, carry_flag, half_byte_borrow_flag, zero_flag}, 8'h04, "borrow flags");
    w_exp = 8'hCF;
  endtask : t_file_ops

  task automatic t_sleep();
    exec(iex_pkg::IEX_OP_SLEEP, 7'h00, 1'b0, 8'h00);
    check({6'h00, expiry_flag, power_down_flag}, 8'h02, "sleep status");
    check(watchdog_counter, 8'h00, "wdog clear");
    check(watchdog_prescaler, 8'h00, "presc clear");
    check({6'h00, osc_run, ready}, 8'h00, "halted");
    start = 1'b1;
    opcode = iex_pkg::IEX_OP_EXCLUSIVE_OR_LITERAL;
    literal = 8'hFF;
    repeat (3) @(negedge clk);
    start = 1'b0;
    check(accumulator, w_exp, "no exec in halt");
    wake = 1'b1;
    repeat (2) @(negedge clk);
    check({6'h00, osc_run, ready}, 8'h00, "wake still synchronising");
    @(negedge clk);
    wake = 1'b0;
    check({6'h00, osc_run, ready}, 8'h03, "woken");
  endtask : t_sleep

  initial begin
    w_exp = 8'h00;
    repeat (12) @(negedge clk);
    check(accumulator, 8'h00, "reset acc");
    check({5'h00, expiry_flag, power_down_flag, osc_run}, 8'h07, "reset status");
    check(dir_a & dir_b & dir_c, 8'hFF, "reset dir");
    resetn = 1'b1;
    @(negedge clk);
    t_xor_literal();
    t_literal_minus();
    t_refused();
    t_direction();
    t_file_to_file();
    t_file_ops();
    t_sleep();
    tally_and_finish();
  end
endmodule : mcu_instruction_execute_subset_bench
`default_nettype wire
